// [core/tmr_regs.svh]
// Constants of the timer event capture block
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_WIDTH 16
`define TMR_MODE_EVT_RISE 3'h0
`define TMR_MODE_EVT_FALL 3'h1
`define TMR_MODE_PWM_NOTOG 3'h4
`define TMR_MODE_PWM_TOG 3'h5
`define TMR_MODE_CAP_ARBR 3'h2
`define TMR_MODE_CAP_ARBF 3'h6
`define TMR_MODE_CAP_AFBR 3'h3
`define TMR_MODE_CAP_AFBF 3'h7
`define TMR_CNT_RESET 16'h0000
`define TMR_CNT_ALL_ONES 16'hFFFF
`endif

// [core/tmr_pkg.sv]
// Types of the timer event capture block
package tmr_pkg;
  typedef enum logic [1:0] {
    TMR_EVT,
    TMR_PWM,
    TMR_CAP
  } tmr_mode_t;
  typedef struct packed {
    logic a;
    logic b;
  } tmr_pins_t;
  typedef struct packed {
    logic prev_a;
    logic prev_b;
  } tmr_edge_state_t;
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] cap_a;
    logic [15:0] cap_b;
    logic pend_a;
    logic pend_b;
    logic uflow;
    logic next_from_b;
    logic pin_a_level;
    logic pin_a_oe;
    logic irq_a;
    logic irq_b;
  } tmr_state_t;
endpackage

// [core/tmr_edge_det.sv]
// Rise and fall detector for the two timer pins
`timescale 1ns/1ps
module tmr_edge_det (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire tmr_pkg::tmr_pins_t pins_in,
  output tmr_pkg::tmr_pins_t rise_out,
  output tmr_pkg::tmr_pins_t fall_out
);
  tmr_pkg::tmr_edge_state_t st;
  tmr_pkg::tmr_edge_state_t next_st;

  always_comb begin
    next_st.prev_a = pins_in.a;
    next_st.prev_b = pins_in.b;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // One event per pin per clock from sample comparison
  assign rise_out.a = pins_in.a & ~st.prev_a;
  assign rise_out.b = pins_in.b & ~st.prev_b;
  assign fall_out.a = ~pins_in.a & st.prev_a;
  assign fall_out.b = ~pins_in.b & st.prev_b;
endmodule

// [core/tmr_block.sv]
// Timer block with event counter, PWM and input capture modes
`timescale 1ns/1ps
`include "tmr_regs.svh"
// Function
// - Event mode counts down on chosen pin-A edge
// - Event mode underflow sets pending A, irq A
// - Event mode pin-B rise sets pending B
// - Event mode never drives pin A
// - Capture mode counts every clock, A/B paired
// - Chosen edge copies timer into capture register
// - Capture edges set pending A and B
// - Capture underflow sets run/underflow bit, irq A
// - Run bit starts or stops PWM/event counting
// - Enable gates irq; pending still records
// - Codes 000/001 event count rise/fall
// - Codes 101/100 PWM with or without toggle
// - Codes 010/110/011/111 capture edge selections
// - Capture irq A is edge or underflow
// - Identical independent copies may be instanced
// - Timer and registers are sixteen bits
// - PWM reloads A first, then alternates from B
module tmr_block (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic timer_pin_a_in,
  input wire logic timer_pin_b_in,
  input wire logic mode_sel_bit1_in,
  input wire logic mode_sel_bit2_in,
  input wire logic mode_sel_bit3_in,
  input wire logic run_or_underflow_bit_in,
  input wire logic run_or_underflow_clr_in,
  input wire logic irq_enable_a_in,
  input wire logic irq_enable_b_in,
  input wire logic pending_a_clr_in,
  input wire logic pending_b_clr_in,
  input wire logic reload_capture_a_we_in,
  input wire logic reload_capture_b_we_in,
  input wire logic [15:0] reload_capture_wdata_in,
  input wire logic timer_we_in,
  output logic [15:0] timer_count_out,
  output logic [15:0] reload_capture_a_out,
  output logic [15:0] reload_capture_b_out,
  output logic pending_a_out,
  output logic pending_b_out,
  output logic underflow_pending_out,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe_out,
  output logic irq_a_out,
  output logic irq_b_out
);
  // ==========================================================
  // Mode decode
  // ==========================================================
  function automatic tmr_pkg::tmr_mode_t decode_mode(
    input logic [2:0] code
  );
    tmr_pkg::tmr_mode_t m;
    m = tmr_pkg::TMR_EVT;
    case (code)
      `TMR_MODE_EVT_RISE, `TMR_MODE_EVT_FALL: m = tmr_pkg::TMR_EVT;
      `TMR_MODE_PWM_TOG, `TMR_MODE_PWM_NOTOG: m = tmr_pkg::TMR_PWM;
      default: m = tmr_pkg::TMR_CAP;
    endcase
    return m;
  endfunction

  logic [2:0] mode_code;
  tmr_pkg::tmr_mode_t mode;
  tmr_pkg::tmr_pins_t pins;
  tmr_pkg::tmr_pins_t rise;
  tmr_pkg::tmr_pins_t fall;
  // All state is local, so several copies stay independent
  tmr_pkg::tmr_state_t st;
  tmr_pkg::tmr_state_t next_st;

  assign mode_code = {mode_sel_bit3_in, mode_sel_bit2_in, mode_sel_bit1_in};
  assign mode = decode_mode(mode_code);
  assign pins.a = timer_pin_a_in;
  assign pins.b = timer_pin_b_in;

  // ==========================================================
  // Edge detection
  // ==========================================================
  tmr_edge_det u_edge (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .pins_in(pins),
    .rise_out(rise),
    .fall_out(fall)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  logic evt_a;
  logic cap_a_edge;
  logic cap_b_edge;
  logic tick;
  logic uf;
  logic set_a;
  logic set_b;
  logic set_uf;

  always_comb begin
    // Event mode edge select: code bit1 picks falling
    evt_a = mode_sel_bit1_in ? fall.a : rise.a;
    // Capture: bit1 picks A falling, bit3 picks B falling
    cap_a_edge = mode_sel_bit1_in ? fall.a : rise.a;
    cap_b_edge = mode_sel_bit3_in ? fall.b : rise.b;
    tick = 1'b0;
    case (mode)
      tmr_pkg::TMR_EVT: tick = run_or_underflow_bit_in & evt_a;
      tmr_pkg::TMR_PWM: tick = run_or_underflow_bit_in;
      tmr_pkg::TMR_CAP: tick = 1'b1;
      default: tick = 1'b0;
    endcase
    uf = tick && (st.count == `TMR_CNT_RESET);
    set_a = 1'b0;
    set_b = 1'b0;
    set_uf = 1'b0;
    next_st = st;
    next_st.pin_a_oe = 1'b0;
    if (tick) begin
      next_st.count = st.count - 16'h0001;
    end
    case (mode)
      tmr_pkg::TMR_EVT: begin
        set_a = uf;
        set_b = rise.b;
      end
      tmr_pkg::TMR_PWM: begin
        next_st.pin_a_oe = 1'b1;
        if (uf) begin
          // First underflow reloads A, then B, A, ...
          next_st.count = st.next_from_b ? st.cap_b : st.cap_a;
          next_st.next_from_b = ~st.next_from_b;
          set_a = ~st.next_from_b;
          set_b = st.next_from_b;
          if (mode_code == `TMR_MODE_PWM_TOG) begin
            next_st.pin_a_level = ~st.pin_a_level;
          end
        end
      end
      tmr_pkg::TMR_CAP: begin
        set_a = cap_a_edge;
        set_b = cap_b_edge;
        set_uf = uf;
        if (cap_a_edge) begin
          next_st.cap_a = st.count;
        end
        if (cap_b_edge) begin
          next_st.cap_b = st.count;
        end
      end
      default: begin
        set_a = 1'b0;
      end
    endcase
    if (mode != tmr_pkg::TMR_PWM) begin
      next_st.next_from_b = 1'b0;
    end
    // Software writes lose to captures in the same cycle
    if (reload_capture_a_we_in &&
        !(mode == tmr_pkg::TMR_CAP && cap_a_edge)) begin
      next_st.cap_a = reload_capture_wdata_in;
    end
    if (reload_capture_b_we_in &&
        !(mode == tmr_pkg::TMR_CAP && cap_b_edge)) begin
      next_st.cap_b = reload_capture_wdata_in;
    end
    if (timer_we_in) begin
      next_st.count = reload_capture_wdata_in;
      next_st.next_from_b = 1'b0;
    end
    // Set wins over a software clear
    next_st.pend_a = set_a | (st.pend_a & ~pending_a_clr_in);
    next_st.pend_b = set_b | (st.pend_b & ~pending_b_clr_in);
    next_st.uflow = set_uf | (st.uflow & ~run_or_underflow_clr_in);
    next_st.irq_a = (next_st.pend_a |
      (mode == tmr_pkg::TMR_CAP && next_st.uflow)) & irq_enable_a_in;
    next_st.irq_b = next_st.pend_b & irq_enable_b_in;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign timer_count_out = st.count;
  assign reload_capture_a_out = st.cap_a;
  assign reload_capture_b_out = st.cap_b;
  assign pending_a_out = st.pend_a;
  assign pending_b_out = st.pend_b;
  assign underflow_pending_out = st.uflow;
  assign timer_pin_a_out = st.pin_a_level;
  assign timer_pin_a_oe_out = st.pin_a_oe;
  assign irq_a_out = st.irq_a;
  assign irq_b_out = st.irq_b;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_evt_underflow;
    mode == tmr_pkg::TMR_EVT && uf;
  endsequence

  chk_evt_count_edge: assert property (
    mode == tmr_pkg::TMR_EVT && !evt_a && !timer_we_in |=> $stable(st.count))
    else $error("event counter moved without edge");
  chk_evt_uflow_pend: assert property (s_evt_underflow |=> st.pend_a)
    else $error("event underflow did not set pending a");
  chk_evt_pinb_pend: assert property (
    mode == tmr_pkg::TMR_EVT && rise.b |=> st.pend_b)
    else $error("pin b rise not recorded");
  chk_evt_no_drive: assert property (
    mode == tmr_pkg::TMR_EVT |=> !timer_pin_a_oe_out)
    else $error("pin a driven in event mode");
  chk_cap_copy_a: assert property (
    mode == tmr_pkg::TMR_CAP && cap_a_edge |=>
      reload_capture_a_out == $past(st.count))
    else $error("capture a wrong value");
  chk_cap_uflow_bit: assert property (
    mode == tmr_pkg::TMR_CAP && uf |=> underflow_pending_out)
    else $error("capture underflow not flagged");
  chk_stop_holds: assert property (
    mode == tmr_pkg::TMR_PWM && !run_or_underflow_bit_in && !timer_we_in
      |=> $stable(st.count))
    else $error("stopped timer moved");
  chk_irq_gate_b: assert property (
    !irq_enable_b_in ##1 !irq_enable_b_in |-> !irq_b_out)
    else $error("irq b without enable");
  chk_pend_sticky: assert property (
    pending_a_out && !pending_a_clr_in |=> pending_a_out)
    else $error("pending a cleared by hardware");
endmodule

// [dv/tmr_pin_src.sv]
// Edge source model driving the two timer pins
`timescale 1ns/1ps
module tmr_pin_src (
  input wire logic ref_clk_in,
  output logic pin_a_out,
  output logic pin_b_out
);
  initial begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end
  // Levels change once per call, so each stays at least one clock
  task automatic set_pins(input logic a, input logic b);
    @(posedge ref_clk_in);
    #1;
    pin_a_out = a;
    pin_b_out = b;
  endtask
endmodule

// [dv/tb_tmr_block.sv]
// Self-checking testbench of the timer event capture block
`timescale 1ns/1ps
module tb_tmr_block;
  typedef struct packed {
    logic [1:0] sel;
    logic [15:0] val;
  } tmr_note_t;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [2:0] m = 3'h0;
  logic run = 1'b0, uclr = 1'b0, ena = 1'b0, enb = 1'b0;
  logic pca = 1'b0, pcb = 1'b0, wea = 1'b0, web = 1'b0, twe = 1'b0;
  logic [15:0] wd = 16'h0000, v;
  logic [15:0] cnt, ca, cb;
  logic pa, pb, uf, pao, poe, ia, ib, pin_a, pin_b;
  logic fa, fb;
  logic [2:0] codes [4] = '{3'h2, 3'h6, 3'h3, 3'h7};
  tmr_note_t q[$];
  tmr_note_t n;
  int n_fail = 0;
  int checks_done = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  tmr_pin_src tmr_pin_src_i (.ref_clk_in(ref_clk_in),
    .pin_a_out(pin_a), .pin_b_out(pin_b));
  tmr_block tmr_block_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .timer_pin_a_in(pin_a), .timer_pin_b_in(pin_b),
    .mode_sel_bit1_in(m[0]), .mode_sel_bit2_in(m[1]),
    .mode_sel_bit3_in(m[2]), .run_or_underflow_bit_in(run),
    .run_or_underflow_clr_in(uclr), .irq_enable_a_in(ena),
    .irq_enable_b_in(enb), .pending_a_clr_in(pca),
    .pending_b_clr_in(pcb), .reload_capture_a_we_in(wea),
    .reload_capture_b_we_in(web), .reload_capture_wdata_in(wd),
    .timer_we_in(twe), .timer_count_out(cnt),
    .reload_capture_a_out(ca), .reload_capture_b_out(cb),
    .pending_a_out(pa), .pending_b_out(pb), .underflow_pending_out(uf),
    .timer_pin_a_out(pao), .timer_pin_a_oe_out(poe),
    .irq_a_out(ia), .irq_b_out(ib));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge ref_clk_in);
    #1;
  endtask
  // Sel 1 count, 2 capture A, 3 flags; 0 capture B
  task automatic expect_val(input logic [1:0] sel, input logic [15:0] val);
    q.push_back({sel, val});
    step();
  endtask
  task automatic clr();
    pca = 1'b1;
    pcb = 1'b1;
    uclr = 1'b1;
    step();
    pca = 1'b0;
    pcb = 1'b0;
    uclr = 1'b0;
  endtask
  task automatic load(input logic [15:0] val);
    wd = val;
    twe = 1'b1;
    step();
    twe = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // Monitor takes the oldest note when a result is due
  always @(negedge ref_clk_in) begin
    if (q.size() != 0) begin
      n = q.pop_front();
      case (n.sel)
        2'h1: check(cnt, n.val);
        2'h2: check(ca, n.val);
        2'h3: check({9'h000, pao, pa, pb, uf, ia, ib, poe}, n.val);
        default: check(cb, n.val);
      endcase
    end
  end
  initial begin
    #3_000_000;
    n_fail++;
    finish_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h7430));
    repeat (16) @(posedge ref_clk_in);
    #1;
    reset_n_in = 1'b1;
    step();
    run = 1'b1;
    ena = 1'b1;
    for (int e = 0; e < 2; e++) begin
      m = 3'(e);
      clr();
      load(16'h0001);
      repeat (2) begin
        tmr_pin_src_i.set_pins(1'b1, 1'b0);
        tmr_pin_src_i.set_pins(1'b0, 1'b0);
      end
      step();
      expect_val(2'h1, 16'hFFFF);
      expect_val(2'h3, 16'h0024);
    end
    run = 1'b0;
    tmr_pin_src_i.set_pins(1'b1, 1'b0);
    tmr_pin_src_i.set_pins(1'b0, 1'b0);
    step();
    expect_val(2'h1, 16'hFFFF);
    ena = 1'b0;
    clr();
    tmr_pin_src_i.set_pins(1'b0, 1'b1);
    step();
    step();
    expect_val(2'h3, 16'h0010);
    enb = 1'b1;
    step();
    expect_val(2'h3, 16'h0012);
    enb = 1'b0;
    clr();
    tmr_pin_src_i.set_pins(1'b0, 1'b0);
    step();
    expect_val(2'h3, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      m = codes[i];
      fa = codes[i][0];
      fb = codes[i][2];
      ena = i[0];
      enb = i[1];
      tmr_pin_src_i.set_pins(fa, fb);
      step();
      clr();
      v = 16'($urandom()) | 16'h0100;
      load(v);
      tmr_pin_src_i.set_pins(~fa, ~fb);
      step();
      step();
      expect_val(2'h2, v - 16'h0001);
      expect_val(2'h0, v - 16'h0001);
      expect_val(2'h3, 16'h0030 | {13'h0000, ena, enb, 1'b0});
    end
    ena = 1'b1;
    enb = 1'b0;
    clr();
    load(16'h0000);
    step();
    step();
    expect_val(2'h3, 16'h000C);
    clr();
    expect_val(2'h3, 16'h0000);
    ena = 1'b0;
    m = 3'h5;
    wd = 16'h0002;
    wea = 1'b1;
    step();
    wea = 1'b0;
    wd = 16'h0003;
    web = 1'b1;
    step();
    web = 1'b0;
    clr();
    run = 1'b1;
    load(16'h0000);
    step();
    expect_val(2'h1, 16'h0002);
    expect_val(2'h3, 16'h0061);
    step();
    expect_val(2'h1, 16'h0003);
    expect_val(2'h3, 16'h0031);
    m = 3'h4;
    repeat (2) step();
    expect_val(2'h1, 16'h0002);
    expect_val(2'h3, 16'h0031);
    step();
    finish_test();
  end
endmodule
